// ### pkg/pmcd_pkg.sv
// shared constants and carriers of the power management clock divider
package pmcd_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] PMCD_IDX_TIMER_CLOCK_CONTROL = 8'h8e;
    localparam logic [7:0] PMCD_IDX_POWER_MANAGEMENT_CONTROL = 8'h80;
    localparam logic [7:0] PMCD_IDX_STATUS = 8'h81;
    localparam int PMCD_ADR_W = 10;

    // divider field codes
    typedef enum logic [1:0] {
        PMCD_DIV_RESERVED = 2'b00,
        PMCD_DIV_4 = 2'b01,
        PMCD_DIV_64 = 2'b10,
        PMCD_DIV_1024 = 2'b11
    } pmcd_div_t;

    // power management control fields
    localparam int PMCD_DIV_SELECT_HIGH = 7;
    localparam int PMCD_DIV_SELECT_LOW = 6;
    localparam int PMCD_SWITCHBACK_EN = 5;
    localparam logic [1:0] PMCD_DIV_RESET = 2'b01;
    localparam logic PMCD_SWITCHBACK_RESET = 1'b0;

    // timer clock control fields and reset
    localparam int PMCD_TIMER_FAST_SELECT_LSB = 3;
    localparam int PMCD_TIMER2_FAST_SELECT = 5;
    localparam logic [7:0] PMCD_TIMER_CLOCK_CONTROL_RESET = 8'h00;

    // status fields
    localparam int PMCD_ST_POWER_FAIL = 7;
    localparam int PMCD_ST_HIGH_PRIO = 6;
    localparam int PMCD_ST_LOW_PRIO = 5;
    localparam int PMCD_ST_SER1_TX = 3;
    localparam int PMCD_ST_SER1_RX = 2;
    localparam int PMCD_ST_SER0_TX = 1;

    // last count of each internal phase; phases last 1, 16 and 256 oscillator clocks
    localparam logic [7:0] PMCD_PHASE_LIM_DIV4 = 8'h00;
    localparam logic [7:0] PMCD_PHASE_LIM_DIV64 = 8'h0f;
    localparam logic [7:0] PMCD_PHASE_LIM_DIV1024 = 8'hff;
    localparam int PMCD_PHASES = 4;
    localparam logic [1:0] PMCD_SLOW_TIMER_LAST = 2'h2;

    // clock enables handed to core and peripherals
    typedef struct packed {
        logic [3:0] phase;
        logic machine;
        logic [2:0] timer;
        logic timer2;
    } pmcd_clk_en_t;
endpackage

// ### rtl/pmcd_sync.sv
// three-stage input synchroniser per bit with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmcd_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw and filtered levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                    s3 <= 1'b1;
                    sync_o[g] <= 1'b1;
                end else begin
                    s1 <= async_i[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        sync_o[g] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### rtl/pmcd_phase_gen.sv
// four-phase generator stretching each phase by the divider code
`timescale 1ns/1ps
`default_nettype none
module pmcd_phase_gen
    import pmcd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // active divider
    input wire pmcd_div_t div_i,
    // phase state
    output logic [1:0] phase_o,
    output logic phase_end_o,
    output logic cycle_end_o
);
    logic [7:0] cnt;
    logic [7:0] lim;

    always_comb begin
        unique case (div_i)
            PMCD_DIV_64: lim = PMCD_PHASE_LIM_DIV64;
            PMCD_DIV_1024: lim = PMCD_PHASE_LIM_DIV1024;
            default: lim = PMCD_PHASE_LIM_DIV4;
        endcase
    end

    assign phase_end_o = (cnt == lim);
    assign cycle_end_o = phase_end_o && (phase_o == 2'(PMCD_PHASES - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            phase_o <= 2'h0;
        end else if (phase_end_o) begin
            cnt <= 8'h00;
            phase_o <= 2'(phase_o + 2'h1);
        end else begin
            cnt <= 8'(cnt + 8'h01);
        end
    end
endmodule
`default_nettype wire

// ### rtl/pmcd_top.sv
// power management clock divider with wishbone register access
`timescale 1ns/1ps
`default_nettype none
module pmcd_top
    import pmcd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [PMCD_ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // interrupt and serial state from core
    input wire logic int_ack_i,
    input wire logic power_fail_busy_i,
    input wire logic high_prio_busy_i,
    input wire logic low_prio_busy_i,
    input wire logic ser1_tx_busy_i,
    input wire logic ser1_rx_busy_i,
    input wire logic ser0_tx_busy_i,
    input wire logic [1:0] tx_load_i,
    input wire logic [1:0] rx_en_i,
    input wire logic [1:0] rx_pin_i,
    // clock enables and mode
    output pmcd_clk_en_t clk_en_o,
    output logic reduced_speed_mode_o,
    output logic crystal_enable_o
);
    // register state
    pmcd_div_t active_div;
    pmcd_div_t target_div;
    logic pend_valid;
    logic switchback_en;
    logic sb_pend;
    logic [7:0] timer_clock_control;
    logic [7:0] status;
    logic [7:0] status_src;

    // bus decode
    logic bus_req;
    logic bus_wr;
    logic [7:0] reg_idx;
    logic idx_ok;
    logic hit_tcc;
    logic hit_pmc;
    logic hit_st;
    logic [7:0] rd_val;
    logic [1:0] wr_div;
    logic wr_legal;
    logic do_pmc_wr;

    // phase generator outputs
    logic [1:0] phase;
    logic phase_end;
    logic cycle_end;

    // serial start detection
    logic [1:0] rx_sync;
    logic [1:0] rx_prev;
    logic [1:0] rx_fall;
    logic int_sb;
    logic tx_sb;
    logic rx_sb;
    logic sb_event;

    // timer pacing
    logic [1:0] mc_mod3;
    logic [2:0] next_timer;

    // enable flops behind the clock enable output
    logic [3:0] phase_en;
    logic machine_en;
    logic [2:0] timer_en;
    logic timer2_en;

    assign bus_req = cyc_i && stb_i;
    assign bus_wr = bus_req && we_i && ack_o && sel_i[0];
    assign reg_idx = adr_i[9:2];
    assign idx_ok = (adr_i[1:0] == 2'b00);
    assign hit_tcc = idx_ok && (reg_idx == PMCD_IDX_TIMER_CLOCK_CONTROL);
    assign hit_pmc = idx_ok && (reg_idx == PMCD_IDX_POWER_MANAGEMENT_CONTROL);
    assign hit_st = idx_ok && (reg_idx == PMCD_IDX_STATUS);

    assign wr_div = dat_i[PMCD_DIV_SELECT_HIGH:PMCD_DIV_SELECT_LOW];
    assign do_pmc_wr = bus_wr && hit_pmc;

    // legal only via divide-by-4; reserved code never accepted
    always_comb begin
        wr_legal = 1'b0;
        if (wr_div == PMCD_DIV_4) begin
            wr_legal = 1'b1;
        end else if (wr_div != PMCD_DIV_RESERVED) begin
            wr_legal = (target_div == PMCD_DIV_4);
        end
    end

    always_comb begin
        rd_val = 8'h00;
        if (hit_tcc) begin
            rd_val = timer_clock_control;
        end else if (hit_pmc) begin
            rd_val[PMCD_DIV_SELECT_HIGH:PMCD_DIV_SELECT_LOW] = target_div;
            rd_val[PMCD_SWITCHBACK_EN] = switchback_en;
        end else if (hit_st) begin
            rd_val = status;
        end
    end

    // classic cycle: ack one cycle after request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req && !ack_o;
        end
    end

    // read data is captured with the request and held until the next one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_req && !ack_o) begin
            dat_o <= {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_clock_control <= PMCD_TIMER_CLOCK_CONTROL_RESET;
        end else if (bus_wr && hit_tcc) begin
            timer_clock_control <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switchback_en <= PMCD_SWITCHBACK_RESET;
        end else if (do_pmc_wr) begin
            switchback_en <= dat_i[PMCD_SWITCHBACK_EN];
        end
    end

    // status mirrors core state one cycle late; unused bits read zero
    always_comb begin
        status_src = 8'h00;
        status_src[PMCD_ST_POWER_FAIL] = power_fail_busy_i;
        status_src[PMCD_ST_HIGH_PRIO] = high_prio_busy_i;
        status_src[PMCD_ST_LOW_PRIO] = low_prio_busy_i;
        status_src[PMCD_ST_SER1_TX] = ser1_tx_busy_i;
        status_src[PMCD_ST_SER1_RX] = ser1_rx_busy_i;
        status_src[PMCD_ST_SER0_TX] = ser0_tx_busy_i;
    end

    genvar s;
    generate
        for (s = 0; s < 8; s++) begin : g_status
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    status[s] <= 1'b0;
                end else begin
                    status[s] <= status_src[s];
                end
            end
        end
    endgenerate

    pmcd_sync #(
        .W(2)
    ) u_rx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(rx_pin_i),
        .sync_o(rx_sync)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev <= 2'b11;
        end else begin
            rx_prev <= rx_sync;
        end
    end

    assign rx_fall = rx_prev & ~rx_sync & rx_en_i;

    // switchback sources, each gated by the enable bit
    assign int_sb = switchback_en && int_ack_i;
    assign tx_sb = switchback_en && (|tx_load_i);
    assign rx_sb = switchback_en && (|rx_fall);
    assign sb_event = int_sb || tx_sb || rx_sb;

    // forced return waits for the next C1; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sb_pend <= 1'b0;
        end else if (sb_event) begin
            sb_pend <= 1'b1;
        end else if (cycle_end || !switchback_en) begin
            sb_pend <= 1'b0;
        end
    end

    // target holds the accepted code until the boundary applies it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            target_div <= PMCD_DIV_4;
        end else if (sb_event || (sb_pend && switchback_en)) begin
            target_div <= PMCD_DIV_4;
        end else if (do_pmc_wr && wr_legal) begin
            target_div <= pmcd_div_t'(wr_div);
        end
    end

    // a pending change survives until the machine-cycle boundary takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_valid <= 1'b0;
        end else if (sb_event || (sb_pend && switchback_en)) begin
            pend_valid <= !cycle_end || sb_event;
        end else if (do_pmc_wr && wr_legal) begin
            pend_valid <= 1'b1;
        end else if (cycle_end) begin
            pend_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_div <= PMCD_DIV_4;
        end else if (cycle_end && sb_pend && switchback_en) begin
            active_div <= PMCD_DIV_4;
        end else if (cycle_end && pend_valid) begin
            active_div <= target_div;
        end
    end

    pmcd_phase_gen u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .div_i(active_div),
        .phase_o(phase),
        .phase_end_o(phase_end),
        .cycle_end_o(cycle_end)
    );

    // machine cycles counted mod three for slow timers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mc_mod3 <= 2'h0;
        end else if (cycle_end) begin
            mc_mod3 <= (mc_mod3 == PMCD_SLOW_TIMER_LAST) ? 2'h0 : 2'(mc_mod3 + 2'h1);
        end
    end

    genvar t;
    generate
        for (t = 0; t < 3; t++) begin : g_timer
            always_comb begin
                if (timer_clock_control[PMCD_TIMER_FAST_SELECT_LSB + t]) begin
                    next_timer[t] = cycle_end;
                end else begin
                    next_timer[t] = cycle_end && (mc_mod3 == PMCD_SLOW_TIMER_LAST);
                end
            end
        end
    endgenerate

    // enables are one-cycle pulses at the start of each stretched phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_en <= 4'h0;
        end else if (phase_end) begin
            phase_en <= 4'(4'h1 << 2'(phase + 2'h1));
        end else begin
            phase_en <= 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            machine_en <= 1'b0;
        end else begin
            machine_en <= cycle_end;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_en <= 3'h0;
        end else begin
            timer_en <= next_timer;
        end
    end

    // timer 2 ticks at the start of C1 and C3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer2_en <= 1'b0;
        end else begin
            timer2_en <= phase_end && phase[0];
        end
    end

    // output bits come straight from the enable flops
    assign clk_en_o = {phase_en, machine_en, timer_en, timer2_en};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reduced_speed_mode_o <= 1'b0;
        end else begin
            reduced_speed_mode_o <= (active_div != PMCD_DIV_4);
        end
    end

    // divider only gates enables; the oscillator itself never stops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crystal_enable_o <= 1'b1;
        end else begin
            crystal_enable_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### verification/pmcd_chk.sv
// port-level assertions for the clock divider
`timescale 1ns/1ps
`default_nettype none
module pmcd_chk
    import pmcd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire pmcd_clk_en_t clk_en_o,
    input wire logic reduced_speed_mode_o,
    input wire logic crystal_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_late_phases;
        clk_en_o.phase[2] ##1 clk_en_o.phase[3];
    endsequence
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    property p_crystal; crystal_enable_o; endproperty
    property p_onehot; $onehot0(clk_en_o.phase); endproperty
    property p_machine; clk_en_o.machine == clk_en_o.phase[0]; endproperty
    property p_div4; clk_en_o.phase[1] && !reduced_speed_mode_o |=> s_late_phases; endproperty
    property p_slow; clk_en_o.phase[1] && reduced_speed_mode_o |=> (clk_en_o.phase == 4'h0)[*8];
    endproperty
    property p_t2; clk_en_o.timer2 == (clk_en_o.phase[0] | clk_en_o.phase[2]); endproperty
    property p_tmr; |clk_en_o.timer |-> clk_en_o.machine; endproperty
    property p_mode;
        $changed(reduced_speed_mode_o) |-> clk_en_o.phase[0] || $past(clk_en_o.phase[0]);
    endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_crystal: assert property (p_crystal) else $error("crystal stopped");
    a_onehot: assert property (p_onehot) else $error("phases overlap");
    a_machine: assert property (p_machine) else $error("machine misplaced");
    a_div4: assert property (p_div4) else $error("div4 phase order");
    a_slow: assert property (p_slow) else $error("slow phase short");
    a_t2: assert property (p_t2) else $error("timer2 clock");
    a_tmr: assert property (p_tmr) else $error("timer off boundary");
    a_mode: assert property (p_mode) else $error("mode change mid cycle");
endmodule
bind pmcd_top pmcd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .clk_en_o(clk_en_o), .reduced_speed_mode_o(reduced_speed_mode_o),
    .crystal_enable_o(crystal_enable_o));
`default_nettype wire

// ### verification/pmcd_core_model.sv
// behavioural core and serial ports feeding the divider's event inputs
`timescale 1ns/1ps
`default_nettype none
module pmcd_core_model (
    // clock and bench commands
    input wire logic clk_i,
    input wire logic [5:0] busy_req_i,
    input wire logic [4:0] ev_i,
    input wire logic [1:0] rx_en_req_i,
    // lines into the divider
    output logic [5:0] busy_o,
    output logic int_ack_o,
    output logic [1:0] tx_load_o,
    output logic [1:0] rx_en_o,
    output logic [1:0] rx_pin_o
);
    logic [5:0] rx_cnt [2];
    initial begin
        busy_o = '0;
        int_ack_o = 0;
        tx_load_o = '0;
        rx_en_o = '0;
        rx_pin_o = 2'h3;
        rx_cnt = '{6'h0, 6'h0};
    end
    always @(posedge clk_i) begin
        busy_o <= busy_req_i;
        int_ack_o <= ev_i[0];
        tx_load_o <= ev_i[2:1];
        rx_en_o <= rx_en_req_i;
        // start bit holds the idle-high line low for a while
        for (int k = 0; k < 2; k++) begin
            if (ev_i[3+k]) rx_cnt[k] <= 6'h20;
            else if (rx_cnt[k] != 6'h0) rx_cnt[k] <= rx_cnt[k] - 6'h01;
            rx_pin_o[k] <= !(ev_i[3+k] || rx_cnt[k] > 6'h01);
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the divider registers and clock enables
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmcd_pkg::*;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
    localparam logic [9:0] PMC = 10'h200;
    localparam logic [9:0] STS = 10'h204;
    localparam logic [9:0] TCC = 10'h238;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, rsm, xtal, int_ack;
    logic [PMCD_ADR_W-1:0] adr_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic [5:0] busy, busy_req = '0;
    logic [4:0] ev = '0;
    logic [1:0] tx_load, rx_en, rx_pin, rx_en_req = '0;
    pmcd_clk_en_t clk_en_o;
    int err_total = 0, total_checks = 0;
    initial forever #5 clk_i = ~clk_i;
    pmcd_core_model u_core (.clk_i(clk_i), .busy_req_i(busy_req), .ev_i(ev),
        .rx_en_req_i(rx_en_req), .busy_o(busy), .int_ack_o(int_ack), .tx_load_o(tx_load),
        .rx_en_o(rx_en), .rx_pin_o(rx_pin));
    pmcd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .int_ack_i(int_ack), .power_fail_busy_i(busy[5]), .high_prio_busy_i(busy[4]),
        .low_prio_busy_i(busy[3]), .ser1_tx_busy_i(busy[2]), .ser1_rx_busy_i(busy[1]),
        .ser0_tx_busy_i(busy[0]), .tx_load_i(tx_load), .rx_en_i(rx_en), .rx_pin_i(rx_pin),
        .clk_en_o(clk_en_o), .reduced_speed_mode_o(rsm), .crystal_enable_o(xtal));
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        rd = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        if (t >= 50) err_total++;
    endtask
    task automatic rdc(input logic [9:0] a, input logic [31:0] e);
        wb(0, a, 8'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_rsm(input logic v);
        int t;
        t = 0;
        while (rsm !== v && t < 3000) begin
            @(posedge clk_i);
            t++;
        end
        `CHK(rsm, v)
    endtask
    // cycles between two pulses of one enable bit
    task automatic meas(input int b, input int e);
        int t;
        t = 0;
        do @(posedge clk_i); while (clk_en_o[b] !== 1'b1 && t++ < 4000);
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (clk_en_o[b] !== 1'b1 && t < 4000);
        `CHK(t, e)
    endtask
    task automatic pulse(input int k);
        ev <= 5'(1 << k);
        @(posedge clk_i);
        ev <= '0;
        @(posedge clk_i);
    endtask
    initial begin
        #500000;
        err_total++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        rdc(PMC, 32'h40);
        rdc(TCC, 32'h0);
        rdc(10'h3fc, 32'h0);
        meas(4, 4);
        meas(1, 12);
        meas(2, 12);
        meas(3, 12);
        meas(0, 2);
        for (int i = 0; i < 6; i++) begin
            busy_req <= 6'(1 << i);
            repeat (2) @(posedge clk_i);
            rdc(STS, 32'h1 << (i < 3 ? i + 1 : i + 2));
        end
        busy_req <= '0;
        wb(1, STS, 8'hff);
        rdc(STS, 32'h0);
        $display("test reset and status done");
        wb(1, PMC, 8'h80);
        rdc(PMC, 32'h80);
        wait_rsm(1);
        `CHK(xtal, 1'b1)
        meas(4, 64);
        meas(1, 192);
        meas(0, 32);
        wb(1, TCC, 8'h08);
        meas(1, 64);
        wb(1, PMC, 8'hc0);
        rdc(PMC, 32'h80);
        wb(1, PMC, 8'h00);
        rdc(PMC, 32'h80);
        wb(1, PMC, 8'h40);
        wait_rsm(0);
        meas(1, 4);
        wb(1, PMC, 8'hc0);
        wait_rsm(1);
        meas(4, 1024);
        meas(0, 512);
        rdc(TCC, 32'h08);
        wb(1, PMC, 8'h40);
        wait_rsm(0);
        wb(1, TCC, 8'h30);
        meas(1, 12);
        meas(2, 4);
        meas(3, 4);
        rdc(TCC, 32'h30);
        $display("test divider done");
        rx_en_req <= 2'h3;
        for (int k = 0; k < 5; k++) begin
            wb(1, PMC, 8'ha0);
            wait_rsm(1);
            pulse(k);
            wait_rsm(0);
            rdc(PMC, 32'h60);
        end
        wb(1, PMC, 8'h80);
        wait_rsm(1);
        pulse(0);
        pulse(1);
        repeat (200) @(posedge clk_i);
        `CHK(rsm, 1'b1)
        rdc(PMC, 32'h80);
        $display("test switchback done");
        rst_i <= 1;
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        `CHK(rsm, 1'b0)
        rdc(PMC, 32'h40);
        rdc(TCC, 32'h0);
        meas(1, 12);
        $display("test mid-run reset done");
        summarize();
    end
endmodule
`default_nettype wire
